// >>> asr_map.svh
// Offsets, field positions, reset values and codes of the sensor status and setup bank
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
`define ASR_OFS_EVENT_FLAGS   8'h1d
`define ASR_OFS_DIE_TEMP      8'h22
`define ASR_OFS_FILL_LOW      8'h24
`define ASR_OFS_FILL_HIGH     8'h25
`define ASR_OFS_READ_PORT     8'h26
`define ASR_OFS_STATE_REPORT  8'h2a
`define ASR_OFS_SAMPLE_SETUP  8'h40
`define ASR_BIT_ACC_DRDY      7
`define ASR_BIT_AUX_DRDY      5
`define ASR_BIT_FIFO_WTM      1
`define ASR_BIT_FIFO_FULL     0
`define ASR_BIT_SLOW_RATE     6
`define ASR_BIT_REMAP         5
`define ASR_RST_EVENT_FLAGS   8'h00
`define ASR_RST_DIE_TEMP      8'h00
`define ASR_RST_READ_PORT     8'h00
`define ASR_RST_SAMPLE_SETUP  8'ha8
`define ASR_RST_FILL          14'h0000
`define ASR_RST_MSG           5'h00
`define ASR_MSG_NOT_INIT      5'h00
`define ASR_MSG_INIT_OK       5'h01
`define ASR_MSG_INIT_ERR      5'h02
`define ASR_MSG_DRV_ERR       5'h03
`define ASR_MSG_SNS_STOP      5'h04
`define ASR_ODR_LOWEST        4'h1
`define ASR_ODR_50HZ          4'h7
`define ASR_ODR_HIGHEST       4'hc
`define ASR_BWP_OSR4          3'h0
`define ASR_BWP_OSR2          3'h1
`define ASR_BWP_NORMAL        3'h2
`define ASR_EMPTY_FILL        8'h00
`endif

// >>> asr_pkg.sv
// Types shared by the sensor status and setup bank
package asr_pkg;
  typedef logic [7:0] asr_byte_t;
  typedef enum logic [2:0] {
    ASR_FILT_OSR4,
    ASR_FILT_OSR2,
    ASR_FILT_NORMAL,
    ASR_FILT_RESERVED,
    ASR_FILT_AVERAGE
  } asr_filter_e;
endpackage

// >>> asr_regs.sv
// Status, temperature, queue level and sample setup register bank of the sensor core
//
// How it works
// R1: Reading the event flag byte returns its flags and then clears them all, except a flag whose event arrives in the same cycle.
// R2: Accel data ready sets bit 7, aux data ready bit 5, queue watermark bit 1, queue full bit 0.
// R3: Die temperature is an 8-bit two's complement value, one kelvin per step, zero at 23 C.
// R4: The 14-bit queue byte count is split into the low byte and bits 5:0 of the high byte.
// R5: The queue read port is a read-only byte register that resets to zero.
// R6: Bits 4:0 of the state report carry the internal status message code.
// R7: Bit 5 of the state report is set when two axes map onto the same physical axis.
// R8: Bit 6 of the state report is set when 50 Hz features run below their needed rate.
// R9: Bits 3:0 of the sample setup select the output data rate, codes 1 to 12 valid.
// R10: In filter mode the bandwidth code selects fourfold, twofold or normal filtering.
// R11: In averaging mode the bandwidth code n averages 2 to the n samples.
// R12: Bit 7 of the sample setup selects averaging (0) or continuous filtering (1).
// R13: The sample setup resets to 0xA8.
// R14: Each queue port read pops one byte; an empty queue returns a fill byte and pops nothing.
// R15: Reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_regs
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_rd,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_rvalid,
  input  wire logic       i_acc_drdy,
  input  wire logic       i_aux_drdy,
  input  wire logic       i_fifo_wtm,
  input  wire logic       i_fifo_full,
  input  wire logic [7:0] i_temperature,
  input  wire logic [13:0] i_fifo_count,
  input  wire logic [7:0] i_fifo_head,
  output logic            o_fifo_pop,
  input  wire logic [4:0] i_status_msg,
  input  wire logic [1:0] i_map_x,
  input  wire logic [1:0] i_map_y,
  input  wire logic [1:0] i_map_z,
  input  wire logic       i_feat50_en,
  output logic      [3:0] o_odr,
  output logic            o_odr_valid,
  output logic      [2:0] o_bwp,
  output logic            o_perf_mode,
  output asr_pkg::asr_filter_e o_filter,
  output logic      [7:0] o_avg_samples
);

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic rd_flags;
  logic rd_port;
  logic wr_setup;
  logic fifo_empty;

  assign rd_flags   = i_rd && (i_addr == `ASR_OFS_EVENT_FLAGS);
  assign rd_port    = i_rd && (i_addr == `ASR_OFS_READ_PORT);
  assign wr_setup   = i_wr && (i_addr == `ASR_OFS_SAMPLE_SETUP);
  assign fifo_empty = (i_fifo_count == `ASR_RST_FILL);

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  localparam int NEV = 4;
  localparam int EV_BIT [NEV] = '{`ASR_BIT_ACC_DRDY, `ASR_BIT_AUX_DRDY,
                                  `ASR_BIT_FIFO_WTM, `ASR_BIT_FIFO_FULL};
  logic [NEV-1:0] ev_in;
  logic [7:0]     flags_r;
  logic [7:0]     flags_nxt;

  assign ev_in = {i_acc_drdy, i_aux_drdy, i_fifo_wtm, i_fifo_full};

  genvar g;
  generate
    for (g = 0; g < NEV; g++)
    begin : g_flag
      // New event wins over the clear of the same cycle
      assign flags_nxt[EV_BIT[g]] = ev_in[NEV-1-g] ||
                                    (flags_r[EV_BIT[g]] && !rd_flags); // see R1 see R2
    end
  endgenerate

  // Reserved flag bits never set
  assign flags_nxt[6] = 1'b0; // see R15
  assign flags_nxt[4] = 1'b0;
  assign flags_nxt[3] = 1'b0;
  assign flags_nxt[2] = 1'b0;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      flags_r <= `ASR_RST_EVENT_FLAGS;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Sampled status: temperature, fill level, state report
  // ----------------------------------------------------------------
  logic [7:0]  temp_r;
  logic [7:0]  temp_nxt;
  logic [13:0] fill_r;
  logic [13:0] fill_nxt;
  logic [4:0]  msg_r;
  logic [4:0]  msg_nxt;
  logic        remap_r;
  logic        remap_nxt;
  logic        slow_r;
  logic        slow_nxt;
  logic [7:0]  setup_r;

  always_comb
  begin
    temp_nxt  = i_temperature; // see R3
    fill_nxt  = i_fifo_count; // see R4
    msg_nxt   = i_status_msg; // see R6
    remap_nxt = (i_map_x == i_map_y) || (i_map_x == i_map_z) ||
                (i_map_y == i_map_z); // see R7
    slow_nxt  = i_feat50_en && (setup_r[3:0] < `ASR_ODR_50HZ); // see R8
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      temp_r  <= `ASR_RST_DIE_TEMP;
      fill_r  <= `ASR_RST_FILL;
      msg_r   <= `ASR_RST_MSG;
      remap_r <= 1'b0;
      slow_r  <= 1'b0;
    end
    else
    begin
      temp_r  <= temp_nxt;
      fill_r  <= fill_nxt;
      msg_r   <= msg_nxt;
      remap_r <= remap_nxt;
      slow_r  <= slow_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Queue read port
  // ----------------------------------------------------------------
  logic [7:0] port_r;
  logic [7:0] port_nxt;

  assign o_fifo_pop = rd_port && !fifo_empty; // see R14

  always_comb
  begin
    port_nxt = port_r;
    if (rd_port)
    begin
      port_nxt = fifo_empty ? `ASR_EMPTY_FILL : i_fifo_head; // see R14
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      port_r <= `ASR_RST_READ_PORT; // see R5
    end
    else
    begin
      port_r <= port_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Sample setup
  // ----------------------------------------------------------------
  logic [7:0] setup_nxt;

  always_comb
  begin
    setup_nxt = setup_r;
    if (wr_setup)
    begin
      setup_nxt = i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      setup_r <= `ASR_RST_SAMPLE_SETUP; // see R13
    end
    else
    begin
      setup_r <= setup_nxt;
    end
  end

  assign o_odr       = setup_r[3:0]; // see R9
  assign o_odr_valid = (setup_r[3:0] >= `ASR_ODR_LOWEST) &&
                       (setup_r[3:0] <= `ASR_ODR_HIGHEST); // see R9
  assign o_bwp       = setup_r[6:4];
  assign o_perf_mode = setup_r[7]; // see R12

  always_comb
  begin
    o_avg_samples = 8'h01;
    if (!setup_r[7])
    begin
      o_avg_samples = 8'(1 << setup_r[6:4]); // see R11
      o_filter      = asr_pkg::ASR_FILT_AVERAGE;
    end
    else
    begin
      case (setup_r[6:4]) // see R10
        `ASR_BWP_OSR4:   o_filter = asr_pkg::ASR_FILT_OSR4;
        `ASR_BWP_OSR2:   o_filter = asr_pkg::ASR_FILT_OSR2;
        `ASR_BWP_NORMAL: o_filter = asr_pkg::ASR_FILT_NORMAL;
        default:         o_filter = asr_pkg::ASR_FILT_RESERVED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;

  always_comb
  begin
    rdata_nxt = 8'h00;
    case (i_addr)
      `ASR_OFS_EVENT_FLAGS:  rdata_nxt = flags_r; // see R1
      `ASR_OFS_DIE_TEMP:     rdata_nxt = temp_r; // see R3
      `ASR_OFS_FILL_LOW:     rdata_nxt = fill_r[7:0]; // see R4
      `ASR_OFS_FILL_HIGH:    rdata_nxt = {2'b00, fill_r[13:8]}; // see R4 see R15
      `ASR_OFS_READ_PORT:    rdata_nxt = port_nxt; // see R5
      `ASR_OFS_STATE_REPORT: rdata_nxt = {1'b0, slow_r, remap_r, msg_r}; // see R15
      `ASR_OFS_SAMPLE_SETUP: rdata_nxt = setup_r;
      default:               rdata_nxt = 8'h00;
    endcase
    if (!i_rd)
    begin
      rdata_nxt = rdata_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= i_rd;
    end
  end

  assign o_rdata  = rdata_r;
  assign o_rvalid = rvalid_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_quiet_flag_read;
    rd_flags && !(|ev_in);
  endsequence

  sequence s_flags_answered;
    (o_rvalid && o_rdata == $past(flags_r)) ##0 (flags_r == 8'h00);
  endsequence

  a_flag_read_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R1
    s_quiet_flag_read |=> s_flags_answered)
    else $error("Event flags not cleared by a read");

  a_flag_set_wins: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R2
    i_acc_drdy |=> flags_r[`ASR_BIT_ACC_DRDY])
    else $error("Accel ready event lost");

  a_full_flag_held: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R2
    (i_fifo_full && !rd_flags) ##1 !rd_flags |=> flags_r[`ASR_BIT_FIFO_FULL])
    else $error("Queue full flag not held");

  a_temp_read_value: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R3
    i_rd && i_addr == `ASR_OFS_DIE_TEMP |-> ##1 o_rdata == $past(temp_r))
    else $error("Temperature read mismatch");

  a_fill_high_split: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R4
    i_rd && i_addr == `ASR_OFS_FILL_HIGH |=> o_rdata == {2'b00, $past(fill_r[13:8])})
    else $error("Fill high byte wrong");

  a_port_pop_once: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R14
    rd_port |-> (o_fifo_pop == !fifo_empty) ##1 (o_rdata == port_r))
    else $error("Queue port pop wrong");

  a_state_remap: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R7
    (i_map_x == i_map_y) |=> remap_r)
    else $error("Remap error not flagged");

  a_state_slow: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R8
    i_feat50_en && setup_r[3:0] < `ASR_ODR_50HZ && $stable(setup_r) |=> slow_r)
    else $error("Slow rate error not flagged");

  a_setup_write: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R12
    wr_setup |=> o_perf_mode == $past(i_wdata[7]) && o_odr == $past(i_wdata[3:0]))
    else $error("Setup write not taken");

  a_avg_samples: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R11
    !o_perf_mode |-> $onehot(o_avg_samples) && o_avg_samples[o_bwp])
    else $error("Averaging count wrong");

  a_read_answer: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R15
    i_rd && i_addr == `ASR_OFS_STATE_REPORT |=> o_rvalid && !o_rdata[7])
    else $error("State report reserved bit set");

endmodule

// >>> asr_queue_model.sv
// Behavioural model of the sample queue that feeds the register bank
`timescale 1ns/1ps

module asr_queue_model
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_pop,
  input  wire logic        i_load,
  input  wire logic [13:0] i_load_count,
  output logic      [13:0] o_count,
  output logic      [7:0]  o_head
);
  // Head byte is a pattern of the fill level so each pop shows a new byte
  assign o_head = o_count[7:0] ^ 8'h5a;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_count <= 14'h0000;
    else if (i_load)
      o_count <= i_load_count;
    else if (i_pop && o_count != 14'h0000)
      o_count <= o_count - 14'h0001;
  end
endmodule

// >>> asr_regs_tb.sv
// Testbench of the sensor status and setup register bank
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_regs_tb;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_wr = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [7:0]  i_wdata = 8'h00;
  logic [7:0]  o_rdata;
  logic        o_rvalid;
  logic [3:0]  ev = 4'h0;
  logic [7:0]  i_temperature = 8'h00;
  logic [13:0] q_count;
  logic [7:0]  q_head;
  logic        o_fifo_pop;
  logic        q_load = 1'b0;
  logic [13:0] q_load_count = 14'h0000;
  logic [4:0]  i_status_msg = 5'h00;
  logic [5:0]  map = 6'h24;
  logic        i_feat50_en = 1'b0;
  logic [3:0]  o_odr;
  logic        o_odr_valid;
  logic [2:0]  o_bwp;
  logic        o_perf_mode;
  asr_pkg::asr_filter_e o_filter;
  logic [7:0]  o_avg_samples;
  int          n_errors = 0;
  int          cmp_count = 0;

  always #20 i_clk = ~i_clk;

  asr_regs u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_rd(i_rd), .i_wr(i_wr),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_acc_drdy(ev[3]), .i_aux_drdy(ev[2]), .i_fifo_wtm(ev[1]), .i_fifo_full(ev[0]),
    .i_temperature(i_temperature), .i_fifo_count(q_count), .i_fifo_head(q_head),
    .o_fifo_pop(o_fifo_pop), .i_status_msg(i_status_msg), .i_map_x(map[5:4]),
    .i_map_y(map[3:2]), .i_map_z(map[1:0]), .i_feat50_en(i_feat50_en), .o_odr(o_odr),
    .o_odr_valid(o_odr_valid), .o_bwp(o_bwp), .o_perf_mode(o_perf_mode),
    .o_filter(o_filter), .o_avg_samples(o_avg_samples));

  asr_queue_model u_queue (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_pop(o_fifo_pop),
    .i_load(q_load), .i_load_count(q_load_count), .o_count(q_count), .o_head(q_head));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step();
    @(posedge i_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    step();
    i_rd = 1'b1;
    i_addr = a;
    step();
    i_rd = 1'b0;
    chk({7'h00, o_rvalid}, 8'h01);
    chk(o_rdata, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step();
    i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    step();
    i_wr = 1'b0;
  endtask

  task automatic summarize();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_errors++;
    summarize();
  end

  initial
  begin
    repeat (6) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    // Reset values and empty queue port
    rd(`ASR_OFS_SAMPLE_SETUP, 8'ha8);
    rd(`ASR_OFS_EVENT_FLAGS, 8'h00);
    rd(`ASR_OFS_READ_PORT, 8'h00);
    chk({4'h0, o_odr}, 8'h08);
    // Event flags, read clears, set wins over clear
    step();
    ev = 4'hf;
    step();
    ev = 4'h0;
    rd(`ASR_OFS_EVENT_FLAGS, 8'ha3);
    rd(`ASR_OFS_EVENT_FLAGS, 8'h00);
    step();
    i_rd = 1'b1;
    i_addr = `ASR_OFS_EVENT_FLAGS;
    ev = 4'h1;
    step();
    i_rd = 1'b0;
    ev = 4'h0;
    chk({7'h00, o_rvalid}, 8'h01);
    chk(o_rdata, 8'h00);
    rd(`ASR_OFS_EVENT_FLAGS, 8'h01);
    // Temperature, queue level and reserved bits
    i_temperature = 8'hf6;
    q_load = 1'b1;
    q_load_count = 14'h3f03;
    step();
    q_load = 1'b0;
    rd(`ASR_OFS_DIE_TEMP, 8'hf6);
    rd(`ASR_OFS_FILL_LOW, 8'h03);
    rd(`ASR_OFS_FILL_HIGH, 8'h3f);
    wr(`ASR_OFS_DIE_TEMP, 8'h11);
    rd(`ASR_OFS_DIE_TEMP, 8'hf6);
    rd(8'h7f, 8'h00);
    // Queue drain, head byte then count one lower
    q_load = 1'b1;
    q_load_count = 14'h0002;
    step();
    q_load = 1'b0;
    rd(`ASR_OFS_READ_PORT, 8'h58);
    rd(`ASR_OFS_READ_PORT, 8'h5b);
    rd(`ASR_OFS_READ_PORT, `ASR_EMPTY_FILL);
    step();
    rd(`ASR_OFS_FILL_LOW, 8'h00);
    // Status message codes, remap and slow rate flags
    for (int m = 0; m < 5; m++)
    begin
      i_status_msg = 5'(m);
      step();
      rd(`ASR_OFS_STATE_REPORT, 8'(m));
    end
    map = 6'h02;
    step();
    rd(`ASR_OFS_STATE_REPORT, 8'h24);
    map = 6'h24;
    i_feat50_en = 1'b1;
    wr(`ASR_OFS_SAMPLE_SETUP, 8'ha6);
    step();
    rd(`ASR_OFS_STATE_REPORT, 8'h44);
    wr(`ASR_OFS_SAMPLE_SETUP, 8'ha7);
    step();
    rd(`ASR_OFS_STATE_REPORT, 8'h04);
    // Rate codes, filter and averaging selections
    for (int c = 0; c < 16; c++)
    begin
      wr(`ASR_OFS_SAMPLE_SETUP, {4'ha, 4'(c)});
      chk({4'h0, o_odr}, 8'(c));
      chk({7'h00, o_odr_valid}, {7'h00, c >= 1 && c <= 12});
    end
    for (int n = 0; n < 8; n++)
    begin
      wr(`ASR_OFS_SAMPLE_SETUP, {1'b0, 3'(n), 4'h8});
      chk(o_avg_samples, 8'h01 << n);
      chk({5'h00, o_filter}, {5'h00, asr_pkg::ASR_FILT_AVERAGE});
      rd(`ASR_OFS_SAMPLE_SETUP, {1'b0, 3'(n), 4'h8});
    end
    for (int n = 0; n < 8; n++)
    begin
      wr(`ASR_OFS_SAMPLE_SETUP, {1'b1, 3'(n), 4'h8});
      chk({5'h00, o_filter}, (n < 3) ? 8'(n) : 8'(asr_pkg::ASR_FILT_RESERVED));
      chk({4'h0, o_perf_mode, o_bwp}, 8'(n + 8));
      chk(o_avg_samples, 8'h01);
    end
    summarize();
  end
endmodule
